// ---- src/lcm_pkg.sv ----
package lcm_pkg;
	// Data-space boundaries seen by the load/store decode
	localparam logic [15:0] IO_BASE = 16'h0020;
	localparam logic [15:0] EXT_IO_BASE = 16'h0060;
	localparam logic [15:0] EXT_IO_LAST = 16'h00ff;
	localparam int IO_ADDR_W = 6;
	// Register byte offsets on the bus
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_OSC_CAL = 8'h04;
	localparam logic [7:0] OFS_BAUD_HI = 8'h08;
	localparam logic [7:0] OFS_RST_FLAGS = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_PORT_DIR = 8'h14;
	// Control field positions
	localparam int CTRL_USART1 = 0;
	localparam int CTRL_USART_SYNC = 1;
	localparam int CTRL_TIMER3 = 2;
	localparam int CTRL_TWO_WIRE = 3;
	localparam int CTRL_BOOT = 4;
	localparam int CTRL_XMEM_REL = 5;
	localparam int CTRL_XMEM_SECT = 6;
	localparam int CTRL_INT_EDGE = 7;
	localparam int CTRL_W = 8;
	// Reset-cause flag positions
	localparam int RF_POR = 0;
	localparam int RF_EXT = 1;
	localparam int RF_W = 5;
	localparam logic [RF_W-1:0] RF_LEGACY_MASK = 5'h03;
	// Values after reset
	localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
	localparam logic [7:0] OSC_CAL_RST = 8'h80;
	localparam logic [3:0] BAUD_HI_RST = 4'h0;
	localparam logic LEGACY_RST = 1'b1;
	localparam logic [2:0] PG_RST_VAL = 3'h3;
	localparam logic [2:0] PG_RST_OE = 3'h7;
	// Receive buffer depth in each mode
	localparam logic [1:0] RX_DEPTH_LEGACY = 2'h1;
	localparam logic [1:0] RX_DEPTH_FULL = 2'h2;
	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;

	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction : in_range
endpackage : lcm_pkg

// ---- src/lcm_addr_route.sv ----
`timescale 1ns/1ps
// Routes one CPU data access to legacy I/O, extended I/O or RAM, one cycle late
module lcm_addr_route (
	input wire logic clock, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic legacy, // Held compatibility mode
	input wire logic acc_valid, // Access this cycle
	input wire logic acc_ldst, // Load/store data access
	input wire logic [15:0] acc_addr, // Data address or I/O number
	output logic io_sel, // Legacy I/O register hit
	output logic ext_io_sel, // Extended I/O register hit
	output logic ram_sel, // Internal RAM hit
	output logic [15:0] route_addr // Data address seen by the target
);
	logic [15:0] data_addr;
	logic hit_io;
	logic hit_ext;

	// Short I/O instructions land 0x20 above their number, same in both modes
	always_comb begin
		if (acc_ldst) begin
			data_addr = acc_addr;
		end else begin
			data_addr = lcm_pkg::IO_BASE + {10'h000, acc_addr[lcm_pkg::IO_ADDR_W-1:0]};
		end
		hit_io = lcm_pkg::in_range(data_addr, lcm_pkg::IO_BASE,
			lcm_pkg::EXT_IO_BASE - 16'h0001);
		hit_ext = acc_ldst && lcm_pkg::in_range(data_addr, lcm_pkg::EXT_IO_BASE,
			lcm_pkg::EXT_IO_LAST);
	end

	// Registered selects; in legacy mode the extended window falls to RAM
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			io_sel <= 1'b0;
			ext_io_sel <= 1'b0;
			ram_sel <= 1'b0;
			route_addr <= 16'h0000;
		end else begin
			io_sel <= acc_valid && hit_io;
			ext_io_sel <= acc_valid && hit_ext && !legacy;
			ram_sel <= acc_valid && acc_ldst && !hit_io && (!hit_ext || legacy);
			route_addr <= data_addr;
		end
	end
endmodule : lcm_addr_route

// ---- src/lcm_pin_ctl.sv ----
`timescale 1ns/1ps
// Pin-direction gating for ports C, F and G
module lcm_pin_ctl (
	input wire logic clock, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic legacy, // Held compatibility mode
	input wire logic xmem_en, // External memory interface owns port G strobes
	input wire logic [7:0] pc_dir, // Software direction, port C
	input wire logic [7:0] pf_dir, // Software direction, port F
	input wire logic [4:0] pg_dir, // Software direction, port G
	output logic [7:0] pc_oe, // Port C drive enable
	output logic pc_in_en, // Port C input path enable
	output logic [7:0] pf_oe, // Port F drive enable
	output logic [4:0] pg_oe, // Port G general-purpose drive enable
	output logic [2:0] pg_force_oe, // Port G bits 2:0 forced drive
	output logic [2:0] pg_force_val // Port G bits 2:0 forced level
);
	// Reset assumes legacy mode, the shipped default, so port C keeps driving
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pc_oe <= 8'hff;
			pc_in_en <= 1'b0;
			pf_oe <= 8'h00;
			pg_oe <= 5'h00;
		end else begin
			pc_oe <= legacy ? 8'hff : pc_dir;
			pc_in_en <= !legacy;
			pf_oe <= legacy ? 8'h00 : pf_dir;
			pg_oe <= legacy ? 5'h00 : pg_dir;
		end
	end

	// Strobe idle levels set without a clock; in legacy mode handed to the memory interface later, otherwise released
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pg_force_oe <= lcm_pkg::PG_RST_OE;
			pg_force_val <= lcm_pkg::PG_RST_VAL;
		end else begin
			pg_force_oe <= {3{legacy && !xmem_en}};
			pg_force_val <= lcm_pkg::PG_RST_VAL;
		end
	end
endmodule : lcm_pin_ctl

// ---- src/lcm_gate.sv ----
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module lcm_gate (
	input wire logic clock, // System clock, 40 MHz
	input wire logic rst_b, // Async reset, active low
	input wire logic legacy_mode_fuse, // Fuse level, high when programmed
	// AHB-Lite slave
	input wire logic hsel, // Slave select
	input wire logic [7:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic hreadyout, // Slave ready
	output logic hresp, // Always OKAY
	output logic [31:0] hrdata, // Read data
	// CPU data access decode
	input wire logic acc_valid, // Access this cycle
	input wire logic acc_ldst, // Load/store, else short I/O instruction
	input wire logic [15:0] acc_addr, // Data address or I/O number
	output logic io_sel, // Legacy I/O hit
	output logic ext_io_sel, // Extended I/O hit
	output logic ram_sel, // Internal RAM hit
	output logic [15:0] route_addr, // Routed address
	// Reset causes and receiver events
	input wire logic [4:0] rst_cause, // One-cycle reset-cause pulses
	input wire logic rx_byte_in, // Receiver completed a byte
	input wire logic rx_byte_read, // Software read a byte
	input wire logic xmem_en, // External memory interface enabled
	// Peripheral gating
	output logic legacy_mode, // Held mode
	output logic ext_vectors_en, // Extended vectors present
	output logic usart1_en, // Second serial port present
	output logic usart_sync_en, // Synchronous serial mode allowed
	output logic [3:0] baud_hi, // Upper baud divider bits
	output logic rx_fifo_en, // Receive FIFO present
	output logic rx_overrun, // Receive overrun flag
	output logic timer3_en, // Second 16-bit timer present
	output logic ocr_c_en, // Third compare register present
	output logic two_wire_iface_en, // Two-wire interface present
	output logic boot_en, // Boot-loader self-programming allowed
	output logic [7:0] osc_cal, // Oscillator calibration applied
	output logic xmem_release_en, // Address pin release allowed
	output logic xmem_sector_en, // Per-section wait states allowed
	output logic wdt_timed_seq, // Watchdog change needs unlock sequence
	output logic [3:0] int_edge_en, // Edge sensing allowed, ints 3..0
	// Pins
	output logic [7:0] pc_oe, // Port C drive enable
	output logic pc_in_en, // Port C input enable
	output logic [7:0] pf_oe, // Port F drive enable
	output logic [4:0] pg_oe, // Port G drive enable
	output logic [2:0] pg_force_oe, // Port G 2:0 forced drive
	output logic [2:0] pg_force_val // Port G 2:0 forced level
);
	logic captured_reg;
	logic legacy_reg;
	logic [lcm_pkg::CTRL_W-1:0] ctrl_reg;
	logic [7:0] osc_cal_reg;
	logic [3:0] baud_hi_reg;
	logic [lcm_pkg::RF_W-1:0] mcu_control_status_reg;
	logic [lcm_pkg::RF_W-1:0] rf_next;
	logic [7:0] pc_dir_reg;
	logic [7:0] pf_dir_reg;
	logic [4:0] pg_dir_reg;
	logic [1:0] rx_count_reg;
	logic [1:0] rx_count_next;
	logic [1:0] rx_depth;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic addr_ok;
	logic [31:0] rd_mux;

	// Fuse caught once at the first edge after release; reset assumes legacy
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			captured_reg <= 1'b0;
			legacy_reg <= lcm_pkg::LEGACY_RST;
		end else if (!captured_reg) begin
			captured_reg <= 1'b1;
			legacy_reg <= legacy_mode_fuse;
		end
	end

	// Bus address phase accepted
	assign addr_ok = hsel && hready && (htrans == lcm_pkg::HTRANS_NONSEQ ||
		htrans == lcm_pkg::HTRANS_SEQ);

	// Write address held for the data phase
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= addr_ok && hwrite;
			wr_addr_reg <= haddr;
		end
	end

	// Zero wait states, so ready and response never move
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Read mux; unused and unmapped bits read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (haddr)
			lcm_pkg::OFS_CTRL: rd_mux = {24'h00_0000, ctrl_reg};
			lcm_pkg::OFS_OSC_CAL: rd_mux = {24'h00_0000, osc_cal_reg};
			lcm_pkg::OFS_BAUD_HI: rd_mux = {28'h000_0000, baud_hi_reg};
			lcm_pkg::OFS_RST_FLAGS: rd_mux = {27'h000_0000, mcu_control_status_reg};
			lcm_pkg::OFS_STATUS: rd_mux = {30'h0000_0000, captured_reg, legacy_reg};
			lcm_pkg::OFS_PORT_DIR: rd_mux = {8'h00, pf_dir_reg, 3'h0, pg_dir_reg, pc_dir_reg};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data captured at the address phase, stands during the data phase
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			hrdata <= rd_mux;
		end
	end

	// Software-written control registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= lcm_pkg::CTRL_RST;
			osc_cal_reg <= lcm_pkg::OSC_CAL_RST;
			baud_hi_reg <= lcm_pkg::BAUD_HI_RST;
			pc_dir_reg <= 8'h00;
			pf_dir_reg <= 8'h00;
			pg_dir_reg <= 5'h00;
		end else if (wr_pend_reg) begin
			unique case (wr_addr_reg)
				lcm_pkg::OFS_CTRL: ctrl_reg <= hwdata[lcm_pkg::CTRL_W-1:0];
				lcm_pkg::OFS_OSC_CAL: osc_cal_reg <= hwdata[7:0];
				lcm_pkg::OFS_BAUD_HI: baud_hi_reg <= hwdata[3:0];
				lcm_pkg::OFS_PORT_DIR: begin
					pc_dir_reg <= hwdata[7:0];
					pg_dir_reg <= hwdata[12:8];
					pf_dir_reg <= hwdata[23:16];
				end
				default: ;
			endcase
		end
	end

	// Reset-cause flags: a new cause beats a same-cycle clear by writing zero
	always_comb begin
		rf_next = mcu_control_status_reg;
		if (wr_pend_reg && wr_addr_reg == lcm_pkg::OFS_RST_FLAGS) begin
			rf_next = rf_next & hwdata[lcm_pkg::RF_W-1:0];
		end
		rf_next = rf_next | rst_cause;
		if (legacy_reg) begin
			rf_next = rf_next & lcm_pkg::RF_LEGACY_MASK;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mcu_control_status_reg <= {lcm_pkg::RF_W{1'b0}};
		end else begin
			mcu_control_status_reg <= rf_next;
		end
	end

	// Unread byte count; legacy has only the data register, no FIFO
	assign rx_depth = legacy_reg ? lcm_pkg::RX_DEPTH_LEGACY : lcm_pkg::RX_DEPTH_FULL;

	always_comb begin
		rx_count_next = rx_count_reg;
		if (rx_byte_read && rx_count_next != 2'h0) begin
			rx_count_next = rx_count_next - 2'h1;
		end
		if (rx_byte_in && rx_count_next != rx_depth) begin
			rx_count_next = rx_count_next + 2'h1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rx_count_reg <= 2'h0;
		end else begin
			rx_count_reg <= rx_count_next;
		end
	end

	// Overrun: set by a byte arriving on a full buffer with no read that cycle; a same-cycle read blocks the set and clears
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rx_overrun <= 1'b0;
		end else if (rx_byte_in && rx_count_reg == rx_depth && !rx_byte_read) begin
			rx_overrun <= 1'b1;
		end else if (rx_byte_read) begin
			rx_overrun <= 1'b0;
		end
	end

	// Feature open only outside legacy mode and when software asks for it
	function automatic logic gate_on(input logic leg, input logic req);
		gate_on = !leg && req;
	endfunction : gate_on

	// Mode and vector table follow the held fuse
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			legacy_mode <= lcm_pkg::LEGACY_RST;
			ext_vectors_en <= 1'b0;
		end else begin
			legacy_mode <= legacy_reg;
			ext_vectors_en <= !legacy_reg;
		end
	end

	// Serial ports; legacy keeps one asynchronous port, low divider byte only
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			usart1_en <= 1'b0;
			usart_sync_en <= 1'b0;
			baud_hi <= 4'h0;
		end else begin
			usart1_en <= gate_on(legacy_reg, ctrl_reg[lcm_pkg::CTRL_USART1]);
			usart_sync_en <= gate_on(legacy_reg, ctrl_reg[lcm_pkg::CTRL_USART_SYNC]);
			baud_hi <= legacy_reg ? 4'h0 : baud_hi_reg;
		end
	end

	// Receive buffer
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rx_fifo_en <= 1'b0;
		end else begin
			rx_fifo_en <= !legacy_reg;
		end
	end

	// Timers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			timer3_en <= 1'b0;
			ocr_c_en <= 1'b0;
		end else begin
			timer3_en <= gate_on(legacy_reg, ctrl_reg[lcm_pkg::CTRL_TIMER3]);
			ocr_c_en <= !legacy_reg;
		end
	end

	// Two-wire interface and self-programming
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			two_wire_iface_en <= 1'b0;
			boot_en <= 1'b0;
		end else begin
			two_wire_iface_en <= gate_on(legacy_reg, ctrl_reg[lcm_pkg::CTRL_TWO_WIRE]);
			boot_en <= gate_on(legacy_reg, ctrl_reg[lcm_pkg::CTRL_BOOT]);
		end
	end

	// Factory value kept in legacy mode so the frequency cannot drift
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			osc_cal <= lcm_pkg::OSC_CAL_RST;
		end else begin
			osc_cal <= legacy_reg ? lcm_pkg::OSC_CAL_RST : osc_cal_reg;
		end
	end

	// External memory interface options
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			xmem_release_en <= 1'b0;
			xmem_sector_en <= 1'b0;
		end else begin
			xmem_release_en <= gate_on(legacy_reg, ctrl_reg[lcm_pkg::CTRL_XMEM_REL]);
			xmem_sector_en <= gate_on(legacy_reg, ctrl_reg[lcm_pkg::CTRL_XMEM_SECT]);
		end
	end

	// Watchdog unlock and interrupt sensing
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wdt_timed_seq <= 1'b0;
			int_edge_en <= 4'h0;
		end else begin
			wdt_timed_seq <= !legacy_reg;
			int_edge_en <= {4{gate_on(legacy_reg, ctrl_reg[lcm_pkg::CTRL_INT_EDGE])}};
		end
	end

	// Data-space routing
	lcm_addr_route i_lcm_addr_route (
		.clock(clock),
		.rst_b(rst_b),
		.legacy(legacy_reg),
		.acc_valid(acc_valid),
		.acc_ldst(acc_ldst),
		.acc_addr(acc_addr),
		.io_sel(io_sel),
		.ext_io_sel(ext_io_sel),
		.ram_sel(ram_sel),
		.route_addr(route_addr)
	);

	// Port pin gating
	lcm_pin_ctl i_lcm_pin_ctl (
		.clock(clock),
		.rst_b(rst_b),
		.legacy(legacy_reg),
		.xmem_en(xmem_en),
		.pc_dir(pc_dir_reg),
		.pf_dir(pf_dir_reg),
		.pg_dir(pg_dir_reg),
		.pc_oe(pc_oe),
		.pc_in_en(pc_in_en),
		.pf_oe(pf_oe),
		.pg_oe(pg_oe),
		.pg_force_oe(pg_force_oe),
		.pg_force_val(pg_force_val)
	);
endmodule : lcm_gate

// ---- sim/lcm_gate_properties.sv ----
`timescale 1ns/1ps
// Watches mode gating, access decode and pin control at the top ports
module lcm_gate_checker (
	input wire logic clock, // Clock
	input wire logic rst_b, // Reset
	input wire logic legacy_mode, // Held mode
	input wire logic acc_valid, // Access
	input wire logic acc_ldst, // Load/store
	input wire logic [15:0] acc_addr, // Address
	input wire logic io_sel, // Legacy I/O hit
	input wire logic ext_io_sel, // Extended hit
	input wire logic ram_sel, // RAM hit
	input wire logic [15:0] route_addr, // Routed address
	input wire logic rx_byte_in, // Byte arrived
	input wire logic rx_byte_read, // Byte read
	input wire logic rx_overrun, // Overrun
	input wire logic xmem_en, // Ext memory on
	input wire logic ext_vectors_en, // Vectors
	input wire logic usart1_en, // Serial 1
	input wire logic usart_sync_en, // Sync serial
	input wire logic [3:0] baud_hi, // Baud high
	input wire logic timer3_en, // Timer 3
	input wire logic two_wire_iface_en, // Two-wire
	input wire logic boot_en, // Boot
	input wire logic [7:0] osc_cal, // Calibration
	input wire logic wdt_timed_seq, // Watchdog unlock
	input wire logic [3:0] int_edge_en, // Edge sense
	input wire logic [7:0] pc_oe, // Port C drive
	input wire logic pc_in_en, // Port C input
	input wire logic [7:0] pf_oe, // Port F drive
	input wire logic [4:0] pg_oe, // Port G drive
	input wire logic [2:0] pg_force_oe, // Port G forced drive
	input wire logic [2:0] pg_force_val // Port G forced level
);
	logic [1:0] up_cnt;

	// Edges since reset; the mode may settle only in the first two
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			up_cnt <= 2'h0;
		end else if (up_cnt != 2'h3) begin
			up_cnt <= up_cnt + 2'h1;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	// Decode, mode gating and pins
	property p_ext_ram;
		(acc_valid && acc_ldst && acc_addr >= 16'h0060 && acc_addr <= 16'h00ff && legacy_mode)
			##1 legacy_mode |-> ram_sel && !ext_io_sel;
	endproperty
	a_ext_ram: assert property (p_ext_ram)
		else $error("extended window not routed to ram");
	property p_ext_io;
		(acc_valid && acc_ldst && acc_addr >= 16'h0060 && acc_addr <= 16'h00ff && !legacy_mode)
			##1 !legacy_mode |-> ext_io_sel && !ram_sel;
	endproperty
	a_ext_io: assert property (p_ext_io)
		else $error("extended window not decoded as io");
	property p_short_io;
		acc_valid && !acc_ldst |=> io_sel && !ext_io_sel
			&& route_addr == 16'h0020 + {10'h000, $past(acc_addr[5:0])};
	endproperty
	a_short_io: assert property (p_short_io)
		else $error("short io access misrouted");
	property p_held;
		up_cnt == 2'h3 |-> $stable(legacy_mode);
	endproperty
	a_held: assert property (p_held)
		else $error("mode changed during run");
	property p_serial_gate;
		legacy_mode |-> !usart1_en && !usart_sync_en && baud_hi == 4'h0 && !timer3_en
			&& !two_wire_iface_en;
	endproperty
	a_serial_gate: assert property (p_serial_gate)
		else $error("serial or timer feature open in legacy mode");
	property p_misc_gate;
		legacy_mode |-> !ext_vectors_en && !boot_en && osc_cal == 8'h80 && !wdt_timed_seq
			&& int_edge_en == 4'h0;
	endproperty
	a_misc_gate: assert property (p_misc_gate)
		else $error("system feature open in legacy mode");
	property p_ports;
		legacy_mode |-> pc_oe == 8'hff && !pc_in_en && pf_oe == 8'h00 && pg_oe == 5'h00;
	endproperty
	a_ports: assert property (p_ports)
		else $error("port direction open in legacy mode");
	property p_pg_force;
		legacy_mode && !xmem_en && !$past(xmem_en) |-> pg_force_oe == 3'h7;
	endproperty
	a_pg_force: assert property (p_pg_force)
		else $error("port g strobes released");
	property p_rst_pins;
		disable iff (1'b0) !rst_b |-> pc_oe == 8'hff && pg_force_oe == 3'h7 && pg_force_val == 3'h3;
	endproperty
	a_rst_pins: assert property (p_rst_pins)
		else $error("pins wrong during reset");
	property p_overrun;
		legacy_mode && rx_byte_in && !rx_byte_read ##1 legacy_mode && rx_byte_in && !rx_byte_read
			|=> rx_overrun;
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun missed on second byte");
endmodule : lcm_gate_checker

bind lcm_gate lcm_gate_checker i_lcm_gate_checker (.*);

// ---- sim/lcm_gate_bench.sv ----
`timescale 1ns/1ps
module lcm_gate_bench;
	logic clock, rst_b, legacy_mode_fuse, hsel, hwrite, hready, hreadyout, hresp;
	logic acc_valid, acc_ldst, io_sel, ext_io_sel, ram_sel, rx_byte_in, rx_byte_read;
	logic xmem_en, legacy_mode, ext_vectors_en, usart1_en, usart_sync_en, rx_fifo_en;
	logic rx_overrun, timer3_en, ocr_c_en, two_wire_iface_en, boot_en, xmem_release_en;
	logic xmem_sector_en, wdt_timed_seq, pc_in_en;
	logic [1:0] htrans;
	logic [2:0] hsize, pg_force_oe, pg_force_val;
	logic [3:0] baud_hi, int_edge_en;
	logic [4:0] rst_cause, pg_oe;
	logic [7:0] haddr, osc_cal, pc_oe, pf_oe;
	logic [15:0] acc_addr, route_addr;
	logic [31:0] hwdata, hrdata;
	int num_errors, total_checks, cycles;

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;

	lcm_gate i_lcm_gate (.*);

	always #12.5 clock = ~clock;

	// Hang guard, far above the hundred-odd cycles the run needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			wrap_up;
		end
	end

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task wait_rdy;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
	endtask : wait_rdy

	// One whole-word transfer; read data taken at the edge closing the data phase
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= lcm_pkg::HTRANS_NONSEQ;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		q = hrdata;
	endtask : bus

	// Selects show for one cycle after the access edge
	task acc(input logic ldst, input logic [15:0] a, input logic [2:0] exp, input logic [15:0] ra);
		@(posedge clock);
		acc_valid <= 1'b1;
		acc_ldst <= ldst;
		acc_addr <= a;
		@(posedge clock);
		acc_valid <= 1'b0;
		#1;
		chk("selects", {io_sel, ext_io_sel, ram_sel}, exp);
		chk("route_addr", route_addr, ra);
	endtask : acc

	// Fill the receiver to its depth with back-to-back bytes, then one byte more
	task rx_fill(input int depth);
		@(posedge clock);
		rx_byte_in <= 1'b1;
		repeat (depth) @(posedge clock);
		#1;
		chk("overrun at depth", rx_overrun, 1'b0);
		@(posedge clock);
		rx_byte_in <= 1'b0;
		#1;
		chk("overrun past depth", rx_overrun, 1'b1);
		@(posedge clock);
		rx_byte_read <= 1'b1;
		@(posedge clock);
		rx_byte_read <= 1'b0;
		@(posedge clock);
		#1;
		chk("overrun cleared", rx_overrun, 1'b0);
	endtask : rx_fill

	// Whole pass with one fuse level; writes try to open every gated feature
	task run_mode(input logic leg);
		logic [31:0] q;
		@(posedge clock);
		legacy_mode_fuse <= leg;
		rst_b <= 1'b0;
		#1;
		chk("pc_oe in reset", pc_oe, 8'hff);
		chk("pg force in reset", {pg_force_oe, pg_force_val}, 6'h3b);
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		repeat (2) @(posedge clock);
		bus(1'b0, lcm_pkg::OFS_STATUS, 32'h0, q);
		chk("status", q, {30'h0, 1'b1, leg});
		bus(1'b1, lcm_pkg::OFS_CTRL, 32'hff, q);
		bus(1'b1, lcm_pkg::OFS_OSC_CAL, 32'h55, q);
		bus(1'b1, lcm_pkg::OFS_BAUD_HI, 32'hf, q);
		bus(1'b1, lcm_pkg::OFS_PORT_DIR, 32'h003c1fa5, q);
		bus(1'b0, 8'hf0, 32'h0, q);
		chk("unmapped read", q, 32'h0);
		chk("unmapped response", {hreadyout, hresp}, 2'h2);
		repeat (2) @(posedge clock);
		#1;
		chk("legacy_mode", legacy_mode, leg);
		chk("serial", {usart1_en, usart_sync_en, baud_hi, rx_fifo_en}, leg ? 7'h0 : 7'h7f);
		chk("timers", {timer3_en, ocr_c_en}, leg ? 2'h0 : 2'h3);
		chk("two wire", two_wire_iface_en, !leg);
		chk("boot", boot_en, !leg);
		chk("osc_cal", osc_cal, leg ? 8'h80 : 8'h55);
		chk("xmem", {xmem_release_en, xmem_sector_en}, leg ? 2'h0 : 2'h3);
		chk("wdt", wdt_timed_seq, !leg);
		chk("int edge", int_edge_en, leg ? 4'h0 : 4'hf);
		chk("vectors", ext_vectors_en, !leg);
		chk("port c", pc_oe, leg ? 8'hff : 8'ha5);
		chk("port f", pf_oe, leg ? 8'h00 : 8'h3c);
		chk("port g", {pg_oe, pg_force_oe}, leg ? 8'h07 : 8'hf8);
		acc(1'b1, 16'h0060, leg ? 3'h1 : 3'h2, 16'h0060);
		acc(1'b1, 16'h00ff, leg ? 3'h1 : 3'h2, 16'h00ff);
		acc(1'b1, 16'h005f, 3'h4, 16'h005f);
		acc(1'b0, 16'h003f, 3'h4, 16'h005f);
		acc(1'b1, 16'h0100, 3'h1, 16'h0100);
		// Memory interface takes the port G strobes, then hands them back
		@(posedge clock);
		xmem_en <= 1'b1;
		repeat (2) @(posedge clock);
		xmem_en <= 1'b0;
		#1;
		chk("strobes to memory", pg_force_oe, 3'h0);
		repeat (2) @(posedge clock);
		#1;
		chk("strobes back", pg_force_oe, leg ? 3'h7 : 3'h0);
		@(posedge clock);
		rst_cause <= 5'h1f;
		@(posedge clock);
		rst_cause <= 5'h00;
		bus(1'b0, lcm_pkg::OFS_RST_FLAGS, 32'h0, q);
		chk("reset flags", q, leg ? 32'h3 : 32'h1f);
		bus(1'b1, lcm_pkg::OFS_RST_FLAGS, 32'h0, q);
		bus(1'b0, lcm_pkg::OFS_RST_FLAGS, 32'h0, q);
		chk("flags cleared", q, 32'h0);
		rx_fill(leg ? 1 : 2);
	endtask : run_mode

	task wrap_up;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	// Full feature set first, so the legacy pass's reset must pull the pins back
	initial begin
		clock = 1'b0;
		rst_b = 1'b1; // Falls at the first edge, so the flops see it
		legacy_mode_fuse = 1'b1;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		acc_valid = 1'b0;
		acc_ldst = 1'b0;
		acc_addr = 16'h0000;
		rst_cause = 5'h00;
		rx_byte_in = 1'b0;
		rx_byte_read = 1'b0;
		xmem_en = 1'b0;
		num_errors = 0;
		total_checks = 0;
		cycles = 0;
		run_mode(1'b0);
		run_mode(1'b1);
		wrap_up;
	end
endmodule : lcm_gate_bench
